/* File: sfhb_map.vh */
// Constants for the synchronous flash host bus interface
`ifndef SFHB_MAP_VH
`define SFHB_MAP_VH

// Address and data pin layout
`define SFHB_ADDR_W        21
`define SFHB_BYTE_SEL_BIT  0
`define SFHB_BANK_SEL_BIT  1
`define SFHB_DATA_W        16

// Output latency setting, in whole clock periods
`define SFHB_LAT_W         3
`define SFHB_LAT_MIN       3'h1

// Queued write-state-machine operations
`define SFHB_QUEUE_W       3
`define SFHB_QUEUE_MAX     3'h7

// Reset values
`define SFHB_DATA_RST      16'h0000
`define SFHB_ADDR_RST      21'h000000
`define SFHB_SYNC_RST      8'h1F

// Identifier codes: arbitrary neutral values
`define SFHB_MFR_CODE      16'h00A5
`define SFHB_DEV_CODE      16'h5A3C

`endif

/* File: sfhb_bus_if.v */
// Pin-level host bus interface of a synchronous pipelined flash memory
`timescale 1ns/1ps
`include "sfhb_map.vh"
module sfhb_bus_if #(
    parameter [15:0] MFR_CODE = `SFHB_MFR_CODE, // arbitrary value
    parameter [15:0] DEV_CODE = `SFHB_DEV_CODE  // arbitrary value
) (
    // Clock and reset
    input  wire                      clk,
    input  wire                      rst_n,
    // Synchronous bus, sampled on clk
    input  wire [`SFHB_ADDR_W-1:0]   addr,
    input  wire                      address_valid_n,
    input  wire [`SFHB_DATA_W-1:0]   data_in,
    // Asynchronous control pins
    input  wire                      powerdown_reset_n,
    input  wire                      chip_select_0_n,
    input  wire                      chip_select_1_n,
    input  wire                      output_enable_n,
    input  wire                      write_enable_n,
    input  wire                      write_protect_n,
    input  wire                      width_select,
    input  wire                      vpp_valid,
    // Data lanes
    output reg  [`SFHB_DATA_W-1:0]   data_lanes_out,
    output reg                       data_low_oe,
    output reg                       data_high_oe,
    // Ready/busy open drain
    output reg                       ready_busy_n_out,
    output reg                       ready_busy_n_oe,
    // Configuration and mode from the command decoder
    input  wire [`SFHB_LAT_W-1:0]    output_latency_setting,
    input  wire                      id_mode_set,
    input  wire                      array_mode_set,
    // Array read port
    output reg                       array_read,
    output reg  [`SFHB_ADDR_W-1:0]   array_addr,
    output reg                       array_bank,
    input  wire [`SFHB_DATA_W-1:0]   array_rdata,
    // Command interface capture
    output reg                       cmd_write,
    output reg  [`SFHB_ADDR_W-1:0]   cmd_addr,
    output reg  [`SFHB_DATA_W-1:0]   cmd_data,
    // Write state machine
    input  wire                      op_request,
    input  wire                      op_is_program,
    input  wire                      block_lock_status_bit,
    input  wire                      op_done,
    input  wire                      erase_suspended,
    output reg                       op_accept,
    output reg                       op_refused,
    output reg                       program_active,
    output reg                       wsm_abort
);

    // Synchroniser stages for asynchronous pins
    reg [7:0] sync_a;
    reg [7:0] sync_b;
    wire      pd_n   = sync_b[0];
    wire      cs_sel = ~sync_b[1] & ~sync_b[2];
    wire      oe_n_s = sync_b[3];
    wire      we_n_s = sync_b[4];
    wire      wp_pin = sync_b[5];
    wire      wide   = sync_b[6];
    wire      vpp_ok = sync_b[7];

    // Internal state
    reg                       we_n_prev;
    reg                       wp_level;
    reg                       id_mode;
    reg [`SFHB_QUEUE_W-1:0]   queue_cnt;
    reg [`SFHB_ADDR_W-1:0]    read_addr;
    reg [`SFHB_LAT_W-1:0]     lat_cnt;
    reg                       lat_run;
    reg                       selected;

    // Derived terms
    wire busy       = (queue_cnt != 3'h0);
    wire low_bit    = wide ? read_addr[`SFHB_BANK_SEL_BIT] : read_addr[`SFHB_BYTE_SEL_BIT];
    wire we_rise    = we_n_s & ~we_n_prev;
    wire protected_ = ~wp_level & block_lock_status_bit;
    wire take_op    = op_request & pd_n & vpp_ok & ~protected_ & (queue_cnt != `SFHB_QUEUE_MAX);
    wire latch_ok   = pd_n & selected & ~address_valid_n & ~program_active;

    // Two-stage synchronisers; the first stage feeds only the second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= `SFHB_SYNC_RST; // Idle pin levels, so no false strobe edge follows reset
            sync_b <= `SFHB_SYNC_RST;
        end else begin
            sync_a <= {vpp_valid, width_select, write_protect_n, write_enable_n,
                       output_enable_n, chip_select_1_n, chip_select_0_n, powerdown_reset_n};
            sync_b <= sync_a;
        end
    end

    // Selection and write-protect tracking
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selected  <= 1'b0;
            we_n_prev <= 1'b1;
            wp_level  <= 1'b0;
        end else begin
            selected  <= cs_sel;
            we_n_prev <= we_n_s;
            if (pd_n)
                wp_level <= wp_pin;
        end
    end

    // Read address latch and array request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_addr  <= `SFHB_ADDR_RST;
            array_read <= 1'b0;
            array_addr <= `SFHB_ADDR_RST;
            array_bank <= 1'b0;
        end else begin
            array_read <= 1'b0;
            if (latch_ok) begin
                read_addr  <= addr;
                array_read <= ~id_mode;
                // byte bit dropped in wide mode
                array_addr <= wide ? {addr[`SFHB_ADDR_W-1:1], 1'b0} : addr;
                array_bank <= addr[`SFHB_BANK_SEL_BIT];
            end
        end
    end

    // Latency counter; state only moves on clock edges so a stopped clock loses nothing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_cnt <= `SFHB_LAT_MIN;
            lat_run <= 1'b0;
        end else if (!pd_n) begin
            lat_run <= 1'b0;
        end else if (latch_ok) begin
            lat_cnt <= (output_latency_setting < `SFHB_LAT_MIN) ? `SFHB_LAT_MIN : output_latency_setting;
            lat_run <= 1'b1;
        end else if (lat_run) begin
            if (lat_cnt == `SFHB_LAT_MIN)
                lat_run <= 1'b0;
            else
                lat_cnt <= lat_cnt - 3'h1;
        end
    end

    // Output data register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_lanes_out <= `SFHB_DATA_RST;
        end else if (lat_run && lat_cnt == `SFHB_LAT_MIN) begin
            if (id_mode) begin
                data_lanes_out <= low_bit ? DEV_CODE : MFR_CODE;
            end else if (wide) begin
                data_lanes_out <= array_rdata;
            end else begin
                data_lanes_out <= {8'h00, read_addr[`SFHB_BYTE_SEL_BIT] ? array_rdata[15:8] : array_rdata[7:0]};
            end
        end
    end

    // Output enables; chip select overrides output-enable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_low_oe  <= 1'b0;
            data_high_oe <= 1'b0;
        end else begin
            // drive only when selected and enabled
            data_low_oe  <= pd_n & cs_sel & ~oe_n_s;
            // high lanes float in byte mode
            data_high_oe <= pd_n & cs_sel & ~oe_n_s & wide;
        end
    end

    // Command interface capture on write strobe rising edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_write <= 1'b0;
            cmd_addr  <= `SFHB_ADDR_RST;
            cmd_data  <= `SFHB_DATA_RST;
        end else begin
            cmd_write <= 1'b0;
            if (we_rise && pd_n && cs_sel && oe_n_s) begin
                cmd_write <= 1'b1;
                cmd_addr  <= addr;
                cmd_data  <= wide ? data_in : {8'h00, data_in[7:0]};
            end
        end
    end

    // Read mode: identifier or array
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_mode <= 1'b0;
        end else if (!pd_n) begin
            id_mode <= 1'b0;
        end else if (array_mode_set) begin
            id_mode <= 1'b0;
        end else if (id_mode_set) begin
            id_mode <= 1'b1;
        end
    end

    // Write state machine queue and handshake
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            queue_cnt      <= 3'h0;
            op_accept      <= 1'b0;
            op_refused     <= 1'b0;
            program_active <= 1'b0;
            wsm_abort      <= 1'b0;
        end else if (!pd_n) begin
            queue_cnt      <= 3'h0;
            op_accept      <= 1'b0;
            op_refused     <= 1'b0;
            program_active <= 1'b0;
            wsm_abort      <= 1'b1;
        end else begin
            wsm_abort  <= 1'b0;
            // locked block refused with protect low
            op_accept  <= take_op;
            op_refused <= op_request & ~take_op;
            case ({take_op, op_done & busy})
                2'b10:   queue_cnt <= queue_cnt + 3'h1;
                2'b01:   queue_cnt <= queue_cnt - 3'h1;
                default: queue_cnt <= queue_cnt;
            endcase
            if (take_op && op_is_program)
                program_active <= 1'b1;
            else if (op_done && queue_cnt == 3'h1)
                program_active <= 1'b0;
        end
    end

    // Ready/busy pin: pulled low only while busy, never floated by selects
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_busy_n_out <= 1'b0;
            ready_busy_n_oe  <= 1'b0;
        end else begin
            ready_busy_n_out <= 1'b0;
            ready_busy_n_oe  <= pd_n & busy & ~erase_suspended;
        end
    end

endmodule

/* File: sfhb_checker.sv */
// Checker for the synchronous flash host bus interface pins
`timescale 1ns/1ps
module sfhb_checker (
    // Clock and reset
    input wire        clk, rst_n,
    // Host pins
    input wire [20:0] addr,
    input wire        address_valid_n, output_enable_n, chip_select_0_n, chip_select_1_n,
    input wire        width_select, write_protect_n, powerdown_reset_n,
    // Machine side
    input wire        op_request, block_lock_status_bit, erase_suspended, op_accept, op_refused,
    // Outputs
    input wire        data_low_oe, data_high_oe, ready_busy_n_out, ready_busy_n_oe,
    input wire        array_read, array_bank, program_active, wsm_abort,
    input wire [20:0] array_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    take_on_valid_a: assert property (
        array_read |-> !$past(address_valid_n) && array_bank == $past(addr[1]) && array_addr[20:2] == $past(addr[20:2])
    ) else $error("read started without a latched address");
    hold_when_idle_a: assert property (address_valid_n |=> !array_read)
        else $error("read started with address valid high");
    prog_ignores_bus_a: assert property (program_active |=> !array_read)
        else $error("read started during program");
    busy_pin_driven_a: assert property (ready_busy_n_out == 1'h0)
        else $error("ready busy pin level not low");
    suspend_frees_a: assert property (erase_suspended |=> !ready_busy_n_oe)
        else $error("busy shown while suspended");
    start_busy_a: assert property (op_accept && !erase_suspended |=> ##[0:1] ready_busy_n_oe)
        else $error("accepted operation not shown busy");
    lock_refused_a: assert property (
        op_request && block_lock_status_bit && !write_protect_n && $past(write_protect_n, 3) == 1'h0
        |=> op_refused && !op_accept) else $error("locked block not refused");
    float_when_off_a: assert property (
        (output_enable_n || chip_select_0_n || chip_select_1_n) [*6] |-> !data_low_oe && !data_high_oe
    ) else $error("data lanes driven while off");
    narrow_high_float_a: assert property ((!width_select) [*6] |-> !data_high_oe)
        else $error("high lanes driven in byte mode");
    powerdown_abort_a: assert property (
        (!powerdown_reset_n) [*6] |-> wsm_abort && !ready_busy_n_oe && !data_low_oe
    ) else $error("powerdown did not abort");
endmodule

bind sfhb_bus_if sfhb_checker CHK (.*);

/* File: sfhb_array_model.sv */
// Behavioural flash array answering the read port
`timescale 1ns/1ps
module sfhb_array_model (
    // Read port
    input  wire [20:0] array_addr,
    input  wire        array_bank,
    output wire [15:0] array_rdata
);
    // bank word answer
    // Row bits high, bank bit low, so a swapped byte lane shows up at once
    assign array_rdata = {array_addr[9:2], 6'h00, array_bank, array_addr[0]};
endmodule

/* File: test_sync_flash_host_bus_interface.sv */
// Self-checking bench for the synchronous flash host bus interface
`timescale 1ns/1ps
`include "sfhb_map.vh"
module test_sync_flash_host_bus_interface;
    typedef struct packed {logic ws; logic id; logic [20:0] a; logic [15:0] e;} sfhb_row_t;
    sfhb_row_t rows [8];
    logic clk = 1'h0, clk_run = 1'h1, rst_n = 1'h0, address_valid_n = 1'h1, powerdown_reset_n = 1'h1;
    logic chip_select_0_n = 1'h0, chip_select_1_n = 1'h0, output_enable_n = 1'h0, write_enable_n = 1'h1;
    logic write_protect_n = 1'h0, width_select = 1'h1, vpp_valid = 1'h1, id_mode_set = 1'h0;
    logic array_mode_set = 1'h0, op_request = 1'h0, op_is_program = 1'h0, block_lock_status_bit = 1'h0;
    logic op_done = 1'h0, erase_suspended = 1'h0, a, r;
    logic [20:0] addr = 21'h000000, array_addr, cmd_addr;
    logic [15:0] data_in = 16'h0000, data_lanes_out, array_rdata, cmd_data;
    logic [2:0]  output_latency_setting = 3'h2;
    logic data_low_oe, data_high_oe, ready_busy_n_out, ready_busy_n_oe, array_read, array_bank;
    logic cmd_write, op_accept, op_refused, program_active, wsm_abort;
    int err_total = 0, checked = 0, cyc = 0;

    sfhb_bus_if DUT (.*);
    sfhb_array_model PARTNER (.*);

    // Clock can be halted to show the pipeline survives a stopped clock
    always #25 if (clk_run) clk = ~clk;

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            conclude;
        end
    end

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task chk(input string n, input logic [20:0] e, v);
        checked++;
        if (v !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, v);
        end
    endtask

    // One latched read; address is scrambled afterwards with valid high
    task rd(input logic [20:0] x);
        addr = x;
        address_valid_n = 1'h0;
        tick(1);
        address_valid_n = 1'h1;
        addr = ~x;
        tick(6);
    endtask

    task op(input logic p, lk);
        op_is_program = p;
        block_lock_status_bit = lk;
        op_request = 1'h1;
        tick(1);
        a = op_accept;
        r = op_refused;
        op_request = 1'h0;
        tick(1);
    endtask

    task conclude;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        rows = '{'{1'h1, 1'h0, 21'h000104, 16'h4100}, '{1'h1, 1'h0, 21'h00020F, 16'h8302},
                 '{1'h0, 1'h0, 21'h000103, 16'h0040}, '{1'h0, 1'h0, 21'h000102, 16'h0002},
                 '{1'h1, 1'h1, 21'h000000, `SFHB_MFR_CODE}, '{1'h1, 1'h1, 21'h000002, `SFHB_DEV_CODE},
                 '{1'h0, 1'h1, 21'h000001, `SFHB_DEV_CODE & 16'h00FF},
                 '{1'h0, 1'h1, 21'h000000, `SFHB_MFR_CODE & 16'h00FF}};
        tick(10);
        chk("lanes idle in reset", 1'h0, data_low_oe);
        rst_n = 1'h1;
        tick(4);
        // Table of reads: width, identifier mode, address, masked lanes
        for (int i = 0; i < 8; i++) begin
            width_select = rows[i].ws;
            id_mode_set = rows[i].id;
            array_mode_set = !rows[i].id;
            tick(1);
            id_mode_set = 1'h0;
            array_mode_set = 1'h0;
            tick(5);
            rd(rows[i].a);
            chk("read lanes", rows[i].e, data_lanes_out & (rows[i].ws ? 16'hFFFF : 16'h00FF));
            chk("high lane drive", rows[i].ws, data_high_oe);
        end
        // Latency setting of 4: data must not land early
        width_select = 1'h1;
        output_latency_setting = 3'h4;
        array_mode_set = 1'h1;
        tick(1);
        array_mode_set = 1'h0;
        tick(4);
        addr = 21'h000204;
        address_valid_n = 1'h0;
        tick(1);
        address_valid_n = 1'h1;
        tick(3);
        chk("early load", 1'h0, data_lanes_out === 16'h8100);
        tick(2);
        chk("latency load", 16'h8100, data_lanes_out);
        clk_run = 1'h0;
        #2000 clk_run = 1'h1;
        tick(3);
        chk("held data", 16'h8100, data_lanes_out);
        chip_select_1_n = 1'h1;
        tick(6);
        chk("deselect float", 1'h0, data_low_oe);
        chip_select_1_n = 1'h0;
        tick(6);
        chk("reselect drive", 1'h1, data_low_oe);
        // Write strobe capture with outputs disabled
        output_enable_n = 1'h1;
        addr = 21'h1ABCDE;
        data_in = 16'hC3A5;
        write_enable_n = 1'h0;
        tick(4);
        write_enable_n = 1'h1;
        for (int n = 0; n < 8 && cmd_write !== 1'h1; n++) tick(1);
        chk("command strobe", 1'h1, cmd_write);
        chk("command address", 21'h1ABCDE, cmd_addr);
        chk("command data", 16'hC3A5, cmd_data);
        chk("lanes off", 1'h0, data_low_oe);
        output_enable_n = 1'h0;
        // Operations against lock, supply and protect
        op(1'h0, 1'h1);
        chk("locked refused", 1'h1, r);
        vpp_valid = 1'h0;
        write_protect_n = 1'h1;
        tick(4);
        op(1'h0, 1'h0);
        chk("supply refused", 1'h1, r);
        vpp_valid = 1'h1;
        tick(4);
        op(1'h0, 1'h1);
        chk("lock overridden", 1'h1, a);
        op(1'h1, 1'h0);
        chk("busy shown", 1'h1, ready_busy_n_oe);
        rd(21'h000004);
        chk("read ignored", 16'h8100, data_lanes_out);
        erase_suspended = 1'h1;
        tick(2);
        chk("suspend ready", 1'h0, ready_busy_n_oe);
        erase_suspended = 1'h0;
        op_done = 1'h1;
        tick(1);
        op_done = 1'h0;
        chip_select_0_n = 1'h1;
        output_enable_n = 1'h1;
        tick(3);
        chk("still busy", 1'h1, ready_busy_n_oe);
        chk("busy while deselected", 1'h1, ready_busy_n_oe);
        chip_select_0_n = 1'h0;
        output_enable_n = 1'h0;
        id_mode_set = 1'h1;
        tick(1);
        id_mode_set = 1'h0;
        powerdown_reset_n = 1'h0;
        tick(6);
        chk("abort", 1'h1, wsm_abort);
        chk("powerdown ready", 1'h0, ready_busy_n_oe);
        op(1'h0, 1'h0);
        chk("powerdown no accept", 1'h0, a);
        powerdown_reset_n = 1'h1;
        tick(6);
        chk("program cleared", 1'h0, program_active);
        rd(21'h000104);
        chk("array mode on exit", 16'h4100, data_lanes_out);
        conclude;
    end
endmodule
